//--- hw/vcd_consts.vh
`ifndef VCD_CONSTS_VH
`define VCD_CONSTS_VH

// ==========================================================
// Register offsets of the virtual CPU interface
`define VCD_OFF_CONTROL      16'h0000
`define VCD_OFF_EOI          16'h0010
`define VCD_OFF_HPPEND       16'h0018
`define VCD_OFF_G1_EOI       16'h0020
`define VCD_OFF_DEACT        16'h1000

// ==========================================================
// Control register fields
`define VCD_CTL_GROUP1_ACK_CONTROL_BIT   2
`define VCD_CTL_SPLIT_COMPLETION_MODE_BIT  9
`define VCD_CTL_MASK         32'h0000_0204
`define VCD_CTL_RESET        32'h0000_0000

// ==========================================================
// Identifier layout and special codes
`define VCD_ID_W             25
`define VCD_ID_MSB           24
`define VCD_ID_SPUR_FIRST    25'h00003FC
`define VCD_ID_SPUR_LAST     25'h00003FF
`define VCD_ID_NO_ACK        25'h00003FE
`define VCD_ID_NONE          25'h00003FF
`define VCD_ID_SGI_LIMIT     25'h0000010
`define VCD_ID_CLR_HI_MASK   25'h0001FFF
`define VCD_ID_CLR_SRC_MASK  25'h1FFE3FF

// ==========================================================
// List entry layout
`define VCD_LE_W             47
`define VCD_LE_NUM           4
`define VCD_LE_IDX_W         2
`define VCD_LE_VID_LSB       0
`define VCD_LE_PID_LSB       25
`define VCD_LE_PID_W         10
`define VCD_LE_PRIO_LSB      35
`define VCD_LE_PRIO_W        8
`define VCD_LE_GRP_BIT       43
`define VCD_LE_HW_BIT        44
`define VCD_LE_PEND_BIT      45
`define VCD_LE_ACT_BIT       46

// ==========================================================
// Active priority bits and orphan counter
`define VCD_APR_W            32
`define VCD_APR_IDX_W        5
`define VCD_CNT_W            5

`endif

//--- hw/vcd_hpsel.v
`timescale 1ns/10ps
`include "vcd_consts.vh"

// ==========================================================
// Highest priority pending entry selector
module vcd_hpsel (
    entries,
    found,
    sel_idx
);
    input  wire [`VCD_LE_NUM*`VCD_LE_W-1:0] entries;
    output reg                              found;
    output reg  [`VCD_LE_IDX_W-1:0]         sel_idx;

    reg [`VCD_LE_PRIO_W-1:0] best_prio;
    reg [`VCD_LE_W-1:0]      ent;
    integer                  i;

    // Lowest priority value wins; lower index wins a tie
    always @* begin
        found     = 1'b0;
        sel_idx   = {`VCD_LE_IDX_W{1'b0}};
        best_prio = {`VCD_LE_PRIO_W{1'b1}};
        ent       = {`VCD_LE_W{1'b0}};
        for (i = 0; i < `VCD_LE_NUM; i = i + 1) begin
            ent = entries[i*`VCD_LE_W +: `VCD_LE_W];
            if (ent[`VCD_LE_PEND_BIT] &&
                (!found || ent[`VCD_LE_PRIO_LSB +: `VCD_LE_PRIO_W] < best_prio)) begin
                found     = 1'b1;
                sel_idx   = i[`VCD_LE_IDX_W-1:0];
                best_prio = ent[`VCD_LE_PRIO_LSB +: `VCD_LE_PRIO_W];
            end
        end
    end

endmodule

//--- hw/vcd_top.v
`timescale 1ns/10ps
`include "vcd_consts.vh"

// Contract
// - Deactivate, end-of-interrupt and query registers hold identifier in bits 24:0.
// - Identifiers 1020 to 1023 are special codes, never real sources.
// - Without affinity routing bits 23:13 zero; bits 12:10 only for SGIs.
// - Deactivate write moves matching active entry to inactive or pending.
// - Deactivate of absent identifier increments the orphan completion counter.
// - Hardware-backed entry deactivation forwards physical identifier to distributor.
// - Forwarded deactivate from deactivate register is ignored for physical Group 0.
// - Deactivate selects purely by identifier, any order, both groups.
// - End-of-interrupt drops priority, and deactivates only when split mode is 0.
// - End-of-interrupt clears highest-priority set active priority bit.
// - Forwarded end-of-interrupt deactivate ignored for Group 0 when security enabled.
// - End-of-interrupt serves Group 0; aliased register serves Group 1.
// - Query register returns highest-priority pending identifier of either group.
// - Group 1 pending: identifier, or 1022 on secure read with ack control 0.
// - Group 0 pending: 1023 on non-secure read; nothing pending: 1023.
// - Single security state interface behaves as for secure reads.
// - Split completion mode sits at control register bit 9.
// - Group 1 acknowledge control sits at control register bit 2.

module vcd_top #(
    parameter SINGLE_SECURITY = 1'b0
) (
    clk,
    rst_n,
    reg_wr,
    reg_rd,
    reg_secure,
    reg_addr,
    reg_wdata,
    reg_rdata,
    lr_wr,
    lr_idx,
    lr_wdata,
    lr_rdata,
    apr_set,
    apr_set_idx,
    apr_bits,
    cnt_clr,
    maint_en,
    orphan_completion_count,
    maint_irq,
    security_disable_bit,
    phys_deact_valid,
    phys_deact_id,
    phys_deact_ign_g0
);
    input  wire                       clk;
    input  wire                       rst_n;
    input  wire                       reg_wr;
    input  wire                       reg_rd;
    input  wire                       reg_secure;
    input  wire [15:0]                reg_addr;
    input  wire [31:0]                reg_wdata;
    output reg  [31:0]                reg_rdata;
    input  wire                       lr_wr;
    input  wire [`VCD_LE_IDX_W-1:0]   lr_idx;
    input  wire [`VCD_LE_W-1:0]       lr_wdata;
    output reg  [`VCD_LE_W-1:0]       lr_rdata;
    input  wire                       apr_set;
    input  wire [`VCD_APR_IDX_W-1:0]  apr_set_idx;
    output reg  [`VCD_APR_W-1:0]      apr_bits;
    input  wire                       cnt_clr;
    input  wire                       maint_en;
    output reg  [`VCD_CNT_W-1:0]      orphan_completion_count;
    output reg                        maint_irq;
    input  wire                       security_disable_bit;
    output reg                        phys_deact_valid;
    output reg  [`VCD_LE_PID_W-1:0]   phys_deact_id;
    output reg                        phys_deact_ign_g0;

    // ==========================================================
    // Reset synchroniser
    reg rst_s1_r;
    reg rst_s2_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // ==========================================================
    // State
    reg  [`VCD_LE_W-1:0]     le_r [0:`VCD_LE_NUM-1];
    reg  [31:0]              ctl_r;
    wire [`VCD_LE_NUM*`VCD_LE_W-1:0] le_flat;
    wire [`VCD_LE_NUM-1:0]   hit_any;
    wire [`VCD_LE_NUM-1:0]   hit_g0;
    wire [`VCD_LE_NUM-1:0]   hit_g1;

    wire [`VCD_ID_MSB:0] wid = reg_wdata[`VCD_ID_MSB:0];
    wire split_mode = ctl_r[`VCD_CTL_SPLIT_COMPLETION_MODE_BIT];
    wire ack_ctl    = ctl_r[`VCD_CTL_GROUP1_ACK_CONTROL_BIT];
    wire wid_spec   = (wid >= `VCD_ID_SPUR_FIRST) && (wid <= `VCD_ID_SPUR_LAST);

    wire wr_deact = reg_wr && (reg_addr == `VCD_OFF_DEACT);
    wire wr_eoi   = reg_wr && (reg_addr == `VCD_OFF_EOI);
    wire wr_g1eoi = reg_wr && (reg_addr == `VCD_OFF_G1_EOI);

    // ==========================================================
    // Per entry identifier match
    genvar g;
    generate
        for (g = 0; g < `VCD_LE_NUM; g = g + 1) begin : g_ent
            wire [`VCD_LE_W-1:0] e = le_r[g];
            assign le_flat[g*`VCD_LE_W +: `VCD_LE_W] = e;
            assign hit_any[g] = (e[`VCD_LE_VID_LSB +: `VCD_ID_W] == wid);
            assign hit_g0[g]  = hit_any[g] && !e[`VCD_LE_GRP_BIT];
            assign hit_g1[g]  = hit_any[g] && e[`VCD_LE_GRP_BIT];
        end
    endgenerate

    // ==========================================================
    // Active priority drop: each bit knows whether a lower bit is set
    wire [`VCD_APR_W-1:0] apr_below;
    wire [`VCD_APR_W-1:0] apr_low;

    generate
        for (g = 0; g < `VCD_APR_W; g = g + 1) begin : g_apr
            if (g == 0) begin : g_first
                assign apr_below[g] = 1'b0;
            end else begin : g_rest
                assign apr_below[g] = apr_below[g-1] || apr_bits[g-1];
            end
            assign apr_low[g] = apr_bits[g] && !apr_below[g];
        end
    endgenerate

    // ==========================================================
    // Deactivation target selection
    reg                     do_deact;
    reg                     from_eoi;
    reg  [`VCD_LE_NUM-1:0]  hits;
    reg                     hit_found;
    reg  [`VCD_LE_IDX_W-1:0] hit_idx;
    reg                     orphan;
    reg                     prio_drop;
    reg  [`VCD_APR_W-1:0]   apr_nxt;
    integer                 k;

    always @* begin
        do_deact  = 1'b0;
        from_eoi  = 1'b0;
        hits      = {`VCD_LE_NUM{1'b0}};
        prio_drop = 1'b0;
        if (wr_deact && !wid_spec) begin
            do_deact = 1'b1;
            hits     = hit_any;
        end else if ((wr_eoi || wr_g1eoi) && !wid_spec) begin
            prio_drop = 1'b1;
            do_deact  = !split_mode;
            from_eoi  = 1'b1;
            hits      = wr_eoi ? hit_g0 : hit_g1;
        end
        hit_found = 1'b0;
        hit_idx   = {`VCD_LE_IDX_W{1'b0}};
        for (k = `VCD_LE_NUM - 1; k >= 0; k = k - 1) begin
            if (hits[k]) begin
                hit_found = 1'b1;
                hit_idx   = k[`VCD_LE_IDX_W-1:0];
            end
        end
        orphan = do_deact && !hit_found;
        // Lowest index is the highest priority active level
        apr_nxt = prio_drop ? (apr_bits & ~apr_low) : apr_bits;
        if (apr_set) begin
            apr_nxt[apr_set_idx] = 1'b1;
        end
    end

    wire [`VCD_LE_W-1:0] tgt = le_r[hit_idx];

    // ==========================================================
    // Highest pending query
    wire                     hp_found;
    wire [`VCD_LE_IDX_W-1:0] hp_idx;

    vcd_hpsel u_hpsel (
        .entries (le_flat),
        .found   (hp_found),
        .sel_idx (hp_idx)
    );

    wire [`VCD_LE_W-1:0]  hp_ent    = le_r[hp_idx];
    wire [`VCD_ID_MSB:0]  hp_raw    = hp_ent[`VCD_LE_VID_LSB +: `VCD_ID_W];
    // Software generated when the low ten bits are below 16 and the entry is not hardware-backed; source sits above them
    wire                  hp_sgi    = ({15'h0000, hp_raw[9:0]} < `VCD_ID_SGI_LIMIT) &&
                                      !hp_ent[`VCD_LE_HW_BIT];
    wire [`VCD_ID_MSB:0]  hp_hi_clr = hp_raw & `VCD_ID_CLR_HI_MASK;
    wire [`VCD_ID_MSB:0]  hp_id     = hp_sgi ? hp_hi_clr
                                             : (hp_hi_clr & `VCD_ID_CLR_SRC_MASK);
    wire                  rd_sec    = reg_secure || SINGLE_SECURITY;

    reg [`VCD_ID_MSB:0] hp_ret;

    always @* begin
        if (!hp_found) begin
            hp_ret = `VCD_ID_NONE;
        end else if (hp_ent[`VCD_LE_GRP_BIT]) begin
            hp_ret = (rd_sec && !ack_ctl) ? `VCD_ID_NO_ACK : hp_id;
        end else begin
            hp_ret = rd_sec ? hp_id : `VCD_ID_NONE;
        end
    end

    // ==========================================================
    // Register read
    reg [31:0] rdata_nxt;

    always @* begin
        case (reg_addr)
            `VCD_OFF_CONTROL: rdata_nxt = ctl_r;
            `VCD_OFF_HPPEND:  rdata_nxt = {7'h00, hp_ret};
            default:          rdata_nxt = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Control and read data
    always @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            ctl_r     <= `VCD_CTL_RESET;
            reg_rdata <= 32'h0000_0000;
        end else begin
            if (reg_wr && reg_addr == `VCD_OFF_CONTROL) begin
                ctl_r <= reg_wdata & `VCD_CTL_MASK;
            end
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    // ==========================================================
    // List entries and active priority bits
    integer j;

    always @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            for (j = 0; j < `VCD_LE_NUM; j = j + 1) begin
                le_r[j] <= {`VCD_LE_W{1'b0}};
            end
            lr_rdata <= {`VCD_LE_W{1'b0}};
            apr_bits <= {`VCD_APR_W{1'b0}};
        end else begin
            apr_bits <= apr_nxt;
            lr_rdata <= le_r[lr_idx];
            // A hypervisor write to the same entry wins over the deactivate
            if (lr_wr) begin
                le_r[lr_idx] <= lr_wdata;
            end
            if (do_deact && hit_found && !(lr_wr && lr_idx == hit_idx)) begin
                le_r[hit_idx][`VCD_LE_ACT_BIT] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Orphan completion counter and maintenance request
    always @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            orphan_completion_count <= {`VCD_CNT_W{1'b0}};
            maint_irq               <= 1'b0;
        end else begin
            // Increment and clear in the same cycle leave a count of 1; the count wraps
            if (orphan) begin
                orphan_completion_count <= cnt_clr ? {{(`VCD_CNT_W-1){1'b0}}, 1'b1}
                                                   : orphan_completion_count + 1'b1;
            end else if (cnt_clr) begin
                orphan_completion_count <= {`VCD_CNT_W{1'b0}};
            end
            maint_irq <= maint_en && (orphan || (!cnt_clr &&
                         orphan_completion_count != {`VCD_CNT_W{1'b0}}));
        end
    end

    // ==========================================================
    // Physical deactivate request
    always @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            phys_deact_valid  <= 1'b0;
            phys_deact_id     <= {`VCD_LE_PID_W{1'b0}};
            phys_deact_ign_g0 <= 1'b0;
        end else begin
            phys_deact_valid <= do_deact && hit_found && tgt[`VCD_LE_HW_BIT];
            if (do_deact && hit_found && tgt[`VCD_LE_HW_BIT]) begin
                phys_deact_id     <= tgt[`VCD_LE_PID_LSB +: `VCD_LE_PID_W];
                phys_deact_ign_g0 <= from_eoi ? !security_disable_bit
                                              : 1'b1;
            end
        end
    end

endmodule

//--- dv/vcd_dist_model.sv
`timescale 1ns/10ps
// ==========================================================
// Distributor end of the physical deactivate path
module vcd_dist_model (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        req,
    input  wire [9:0]  pid,
    input  wire        ign_g0,
    output logic [7:0] acc_cnt
);
    // Odd physical ids are Group 1 here, even ones Group 0
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            acc_cnt <= 8'h00;
        else if (req && !(ign_g0 && !pid[0]))
            acc_cnt <= acc_cnt + 8'h01;
    end
endmodule

//--- dv/vcd_top_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
module vcd_top_sva (
    input wire        clk,
    input wire        rst_n,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire        apr_set,
    input wire [31:0] apr_bits,
    input wire        cnt_clr,
    input wire        maint_en,
    input wire [4:0]  orphan_completion_count,
    input wire        maint_irq,
    input wire        security_disable_bit,
    input wire        phys_deact_valid,
    input wire        phys_deact_ign_g0
);
    wire spc = reg_wdata[24:2] == 23'h0000FF;
    wire cmp = reg_wr && (reg_addr == 16'h1000 || reg_addr == 16'h0010 || reg_addr == 16'h0020);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_special_id_inert: assert property (cmp && spc && !cnt_clr |=>
        !phys_deact_valid && $stable(orphan_completion_count)) else $error("special id acted on");
    a_fwd_has_cause: assert property (phys_deact_valid |-> $past(cmp))
        else $error("request without write");
    a_deact_ign_g0: assert property (phys_deact_valid && $past(reg_addr) == 16'h1000
        |-> phys_deact_ign_g0) else $error("deactivate request not marked");
    a_eoi_ign_sec: assert property (phys_deact_valid && $past(reg_addr) != 16'h1000
        |-> phys_deact_ign_g0 == !$past(security_disable_bit)) else $error("eoi mark wrong");
    a_apr_low_drop: assert property (reg_wr && reg_addr == 16'h0010 && !spc && !apr_set
        |=> apr_bits == ($past(apr_bits) & ($past(apr_bits) - 32'h1))) else $error("apr drop");
    a_count_step: assert property ($changed(orphan_completion_count) |->
        (orphan_completion_count == $past(orphan_completion_count) + 5'h1 && $past(cmp))
        || (orphan_completion_count == 5'h0 && $past(cnt_clr))
        || (orphan_completion_count == 5'h1 && $past(cnt_clr) && $past(cmp)))
        else $error("count step");
    a_maint_level: assert property (maint_irq == ($past(maint_en) &&
        orphan_completion_count != 5'h0)) else $error("maint level");
    a_read_resv_zero: assert property (reg_rd |=> reg_rdata[31:25] == 7'h00)
        else $error("reserved read bits");
    a_ctl_two_bits: assert property (reg_rd && reg_addr == 16'h0000 |=>
        (reg_rdata & 32'hFFFFFDFB) == 32'h0) else $error("control bits");
    a_query_hi_zero: assert property (reg_rd && reg_addr == 16'h0018 |=>
        reg_rdata[23:13] == 11'h000) else $error("query high bits");
    c_marked: cover property (phys_deact_valid && phys_deact_ign_g0);
    c_maint: cover property (maint_irq);
    c_query: cover property (reg_rd && reg_addr == 16'h0018);
endmodule
bind vcd_top vcd_top_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .apr_set(apr_set),
    .apr_bits(apr_bits), .cnt_clr(cnt_clr), .maint_en(maint_en),
    .orphan_completion_count(orphan_completion_count), .maint_irq(maint_irq),
    .security_disable_bit(security_disable_bit), .phys_deact_valid(phys_deact_valid),
    .phys_deact_ign_g0(phys_deact_ign_g0));

//--- dv/vcd_top_bench.sv
`timescale 1ns/10ps
module vcd_top_bench;
    logic        clk, rst_n, wr, rd, sec, lw, aps, clr, men, sdb, pv, pg, mi;
    logic [15:0] ad;
    logic [31:0] wd, rdat, apr, lf, rv, rds;
    logic [46:0] lwd, lrd, e;
    logic [24:0] v;
    logic [9:0]  pid, pdi;
    logic [4:0]  api, occ;
    logic [1:0]  li;
    logic [7:0]  acc;
    int          bad_count, n_checks, cyc, accx;
    vcd_top dut (.clk(clk), .rst_n(rst_n), .reg_wr(wr), .reg_rd(rd), .reg_secure(sec),
        .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat), .lr_wr(lw), .lr_idx(li),
        .lr_wdata(lwd), .lr_rdata(lrd), .apr_set(aps), .apr_set_idx(api), .apr_bits(apr),
        .cnt_clr(clr), .maint_en(men), .orphan_completion_count(occ), .maint_irq(mi),
        .security_disable_bit(sdb), .phys_deact_valid(pv), .phys_deact_id(pdi),
        .phys_deact_ign_g0(pg));
    vcd_top #(.SINGLE_SECURITY(1'b1)) dut_single (.clk(clk), .rst_n(rst_n), .reg_wr(wr),
        .reg_rd(rd), .reg_secure(sec), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rds),
        .lr_wr(lw), .lr_idx(li), .lr_wdata(lwd), .lr_rdata(), .apr_set(aps),
        .apr_set_idx(api), .apr_bits(), .cnt_clr(clr), .maint_en(men),
        .orphan_completion_count(), .maint_irq(), .security_disable_bit(sdb),
        .phys_deact_valid(), .phys_deact_id(), .phys_deact_ign_g0());
    vcd_dist_model u_dist (.clk(clk), .rst_n(rst_n), .req(pv), .pid(pdi), .ign_g0(pg),
        .acc_cnt(acc));
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [46:0] mk(input logic [24:0] id, input logic [9:0] p,
        input logic g, input logic h, input logic pe, input logic a);
        return {a, pe, h, g, 8'h40, p, id};
    endfunction
    function automatic logic [31:0] hpx(input logic [24:0] id, input logic g, input logic s,
        input logic a);
        if (g && s && !a)
            return 32'h000003FE;
        if (!g && !s)
            return 32'h000003FF;
        return {7'h00, id & 25'h00003FF};
    endfunction
    task automatic chk(input string nm, input logic [46:0] ex, input logic [46:0] got);
        n_checks++;
        if (got !== ex) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic bus(input logic w, input logic s, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        sec <= s;
        ad <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 rv = rdat;
    endtask
    task automatic lget(input logic [1:0] i);
        @(posedge clk);
        li <= i;
        @(posedge clk);
        #1 e = lrd;
    endtask
    task automatic lset(input logic [1:0] i, input logic [46:0] d);
        @(posedge clk);
        lw <= 1'b1;
        li <= i;
        lwd <= d;
        @(posedge clk);
        lw <= 1'b0;
        @(posedge clk);
        #1 e = lrd;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        {rst_n, wr, rd, sec, lw, aps, clr, men, sdb, ad, wd, li, lwd, api} = '0;
        lf = 32'hC100;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1, 0, 16'h0000, 32'hFFFFFFFF);
        bus(0, 0, 16'h0000, 32'h0);
        chk("control", 32'h00000204, rv);
        bus(0, 0, 16'h0004, 32'h0);
        chk("unmapped", 32'h0, rv);
        $display("test control done");
        for (int k = 0; k < 8; k++) begin
            lf = nx(lf);
            v = {1'b0, lf[23:10], 2'h1, lf[7:0]};
            bus(1, 0, 16'h0000, {29'h0, k[2], 2'h0});
            lset(2, mk(v, 10'h0, k[0], 0, 1, 0));
            lset(3, mk(25'h1FF, 10'h0, !k[0], 0, 1, 0) | 47'h8000000000);
            bus(0, k[1], 16'h0018, 32'h0);
            chk("query", hpx(v, k[0], k[1], k[2]), rv);
            chk("query single", hpx(v, k[0], 1'b1, k[2]), rds);
        end
        lset(2, mk({12'h000, 3'h5, 10'h003}, 10'h0, 0, 0, 1, 0));
        bus(0, 1, 16'h0018, 32'h0);
        chk("query sgi", 32'h00001403, rv);
        lset(2, 47'h0);
        lset(3, 47'h0);
        bus(0, 1, 16'h0018, 32'h0);
        chk("query empty", 32'h000003FF, rv);
        $display("test query done");
        bus(1, 0, 16'h0000, 32'h00000200);
        for (int j = 0; j < 4; j++) begin
            lf = nx(lf);
            v = {15'h0, 2'h1, j[1:0], lf[5:0]};
            pid = lf[25:16];
            lset(j[1:0], mk(v, pid, lf[1], 1, lf[0], 1));
            bus(1, 0, 16'h1000, {7'h7F, v});
            chk("fwd valid", 1, pv);
            chk("fwd id", pid, pdi);
            chk("fwd mark", 1, pg);
            accx += pid[0];
            lget(j[1:0]);
            chk("entry", mk(v, pid, lwd[43], 1, lwd[45], 0), e);
        end
        men <= 1'b1;
        bus(1, 0, 16'h1000, 32'h000000F0);
        chk("orphan", 1, occ);
        chk("maint", 1, mi);
        bus(1, 0, 16'h1000, 32'h000003FE);
        chk("special", 1, occ);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1 chk("cleared", 0, occ);
        $display("test deactivate done");
        for (int m = 0; m < 2; m++) begin
            lf = nx(lf);
            bus(1, 0, 16'h0000, {22'h0, m[0], 9'h0});
            @(posedge clk);
            aps <= 1'b1;
            api <= 5'h03;
            sdb <= lf[1];
            @(posedge clk);
            api <= 5'h07;
            @(posedge clk);
            aps <= 1'b0;
            lset(0, mk(25'h050, lf[9:0], 0, 1, 0, 1));
            bus(1, 0, 16'h0010, 32'h00000050);
            chk("apr drop", 32'h00000080, apr);
            chk("eoi fwd", !m[0], pv);
            if (m == 0) begin
                chk("eoi mark", !lf[1], pg);
                accx += lf[0] | lf[1];
            end
            lget(0);
            chk("eoi entry", mk(25'h050, lf[9:0], 0, 1, 0, m[0]), e);
            lset(1, mk(25'h060, lf[9:0], 1, 0, 0, 1));
            bus(1, 0, 16'h0020, 32'h00000060);
            lget(1);
            chk("g1 eoi", mk(25'h060, lf[9:0], 1, 0, 0, m[0]), e);
            bus(1, 0, 16'h0010, 32'h00000080);
        end
        chk("dist count", accx[7:0], acc);
        $display("test eoi done");
        end_sim();
    end
endmodule
